/* design/ast_pkg.sv */
// Purpose: Shared constants and types for the async serial transceiver
// Assumes: AXI4-Lite register access, 32-bit data, one register per word
// Notes: Registers are 8 bits wide in the low byte of each word
`default_nettype none
package ast_pkg;
  localparam int unsigned ADDR_W = 8;
  localparam logic [7:0] OFS_TX_CTRL = 8'h00;
  localparam logic [7:0] OFS_RX_STAT = 8'h04;
  localparam logic [7:0] OFS_BAUD_CTRL = 8'h08;
  localparam logic [7:0] OFS_DIV_LO = 8'h0c;
  localparam logic [7:0] OFS_DIV_HI = 8'h10;
  localparam logic [7:0] OFS_TX_BUF = 8'h14;
  localparam logic [7:0] OFS_RX_BUF = 8'h18;
  localparam logic [7:0] OFS_FLAGS = 8'h1c;
  localparam logic [7:0] OFS_ENABLES = 8'h20;
  // Bit positions
  localparam int unsigned B_TX9 = 6;
  localparam int unsigned B_TRANSMIT_ENABLE = 5;
  localparam int unsigned B_SYNC = 4;
  localparam int unsigned B_HIGH_BAUD_SELECT = 2;
  localparam int unsigned B_SHIFTER_EMPTY = 1;
  localparam int unsigned B_TRANSMIT_NINTH_BIT = 0;
  localparam int unsigned B_SERIAL_PORT_ENABLE = 7;
  localparam int unsigned B_RX9 = 6;
  localparam int unsigned B_CONTINUOUS_RECEIVE_ENABLE = 4;
  localparam int unsigned B_ADDRESS_DETECT_ENABLE = 3;
  localparam int unsigned B_FERR = 2;
  localparam int unsigned B_OERR = 1;
  localparam int unsigned B_RX9D = 0;
  localparam int unsigned B_RECEIVE_POLARITY = 5;
  localparam int unsigned B_TRANSMIT_POLARITY = 4;
  localparam int unsigned B_WIDE_DIVISOR_SELECT = 3;
  localparam int unsigned B_RECEIVE_COMPLETE_FLAG = 5;
  localparam int unsigned B_TRANSMIT_BUFFER_EMPTY_FLAG = 4;
  // Oversampling ratios, as last-phase index
  localparam logic [5:0] OVS16_LAST = 6'h0f;
  localparam logic [5:0] OVS64_LAST = 6'h3f;
  localparam logic [3:0] BITS8_LAST = 4'h7;
  localparam logic [3:0] BITS9_LAST = 4'h8;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef struct packed {
    logic tx9;
    logic transmit_enable;
    logic sync;
    logic high_baud_select;
    logic transmit_ninth_bit;
    logic serial_port_enable;
    logic rx9;
    logic continuous_receive_enable;
    logic address_detect_enable;
    logic receive_polarity;
    logic transmit_polarity;
    logic wide_divisor_select;
    logic transmit_interrupt_enable;
    logic receive_interrupt_enable;
  } ast_cfg_s;
  typedef enum logic [1:0] {ST_IDLE, ST_START, ST_DATA, ST_STOP} ast_line_e;
endpackage
`default_nettype wire

/* design/ast_top.sv */
// Purpose: Asynchronous serial transmitter and receiver with AXI4-Lite registers
// Assumes: i_rx_line synchronous to i_sys_clk; one instruction cycle is one clock
// Notes: Baud tick period is divisor+1 clocks
// Notes on behaviour
// - Port runs asynchronous NRZ frames only while clocked-mode select is zero.
// - Data words shift out and in least significant bit first.
// - Transmitter and receiver are independent but share format and baud rate.
// - Bit rate divider is 8 or 16 bits, loaded from divisor registers.
// - Baud tick is x16 or x64 the bit rate by select bits.
// - No parity hardware; software carries parity in the ninth bit.
// - Polarity bits invert transmit line and sampled receive line.
// - Shifter loads from buffer right after stop bit, if buffer holds data.
// - Buffer to shifter transfer takes one cycle and sets buffer-empty flag.
// - Buffer-empty flag ignores its enable and cannot be cleared by software.
// - Buffer-empty flag clears by second cycle after a buffer write.
// - Read-only shifter-empty bit, high while shifter empty, no interrupt.
// - Transmit enable sets buffer-empty flag; port active needs enable, async mode.
// - Ninth transmit bit is set before buffer write and sent ninth.
// - Buffer write starts a frame; configuration must come first.
// - Receive line sampled at the x16 or x64 baud tick rate; shifter moves per bit.
// - Completed frame sets receive-complete flag; request only if enabled.
// - Ninth bit and errors in receive status, eight bits in buffer.
// - Clearing continuous-receive enable clears pending receive errors.
// - Address detect enable with nine-bit receive turns on address detection.
// - Without address detect every frame is accepted and requests.
//
// The AXI4-Lite interface to the registers and the placing of the registers were decided locally.
`default_nettype none
module ast_top (
  input wire logic i_sys_clk,
  input wire logic i_rst_n,
  input wire logic i_axi_awvalid,
  output logic o_axi_awready,
  input wire logic [ast_pkg::ADDR_W-1:0] i_axi_awaddr,
  input wire logic i_axi_wvalid,
  output logic o_axi_wready,
  input wire logic [31:0] i_axi_wdata,
  input wire logic [3:0] i_axi_wstrb,
  output logic o_axi_bvalid,
  input wire logic i_axi_bready,
  output logic [1:0] o_axi_bresp,
  input wire logic i_axi_arvalid,
  output logic o_axi_arready,
  input wire logic [ast_pkg::ADDR_W-1:0] i_axi_araddr,
  output logic o_axi_rvalid,
  input wire logic i_axi_rready,
  output logic [31:0] o_axi_rdata,
  output logic [1:0] o_axi_rresp,
  input wire logic i_rx_line,
  output logic o_tx_line,
  output logic o_tx_irq_req,
  output logic o_rx_irq_req
);
  ast_pkg::ast_cfg_s cfg_q;
  logic [7:0] div_lo_q, div_hi_q, txbuf_q, rxbuf_q;
  logic txbuf_full_q, transmit_buffer_empty_flag_q, receive_complete_flag_q, ferr_q, oerr_q, rx9d_q;
  logic aw_hold_q, w_hold_q, wstrb0_q;
  logic [ast_pkg::ADDR_W-1:0] awaddr_q;
  logic [7:0] wdata_q;
  logic wr_go, rd_go, wr_ok, txbuf_wr, rxbuf_rd;
  logic active, tx_load, rx_done, rx_accept;
  logic [15:0] baud_cnt_q, divisor;
  logic tick;
  logic [5:0] ovs_last;
  ast_pkg::ast_line_e tx_st_q, rx_st_q;
  logic [5:0] tx_ph_q, rx_ph_q;
  logic [3:0] tx_bit_q, rx_bit_q;
  logic [8:0] tsr_q, rsr_q;
  logic rx_s;

  function automatic logic is_mapped(input logic [ast_pkg::ADDR_W-1:0] a);
    is_mapped = (a[1:0] == 2'h0) && (a <= ast_pkg::OFS_ENABLES);
  endfunction

  // AXI4-Lite write path: address and data accepted in either order
  assign o_axi_awready = !aw_hold_q;
  assign o_axi_wready = !w_hold_q;
  assign wr_go = aw_hold_q && w_hold_q && !o_axi_bvalid;
  // A write without lane 0 is dropped but still answered OKAY
  assign wr_ok = wr_go && is_mapped(awaddr_q) && wstrb0_q;
  assign txbuf_wr = wr_ok && (awaddr_q == ast_pkg::OFS_TX_BUF);

  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      aw_hold_q <= 1'b0;
      w_hold_q <= 1'b0;
      awaddr_q <= '0;
      wdata_q <= '0;
    end else begin
      if (i_axi_awvalid && o_axi_awready) begin
        aw_hold_q <= 1'b1;
        awaddr_q <= i_axi_awaddr;
      end else if (wr_go) begin
        aw_hold_q <= 1'b0;
      end
      if (i_axi_wvalid && o_axi_wready) begin
        w_hold_q <= 1'b1;
        // Lanes above the low byte hold nothing; a write without lane 0 keeps old value
        wdata_q <= i_axi_wstrb[0] ? i_axi_wdata[7:0] : 8'h00;
      end else if (wr_go) begin
        w_hold_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      wstrb0_q <= 1'b0;
    end else if (i_axi_wvalid && o_axi_wready) begin
      wstrb0_q <= i_axi_wstrb[0];
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      o_axi_bvalid <= 1'b0;
      o_axi_bresp <= ast_pkg::RESP_OKAY;
    end else if (wr_go) begin
      o_axi_bvalid <= 1'b1;
      o_axi_bresp <= is_mapped(awaddr_q) ? ast_pkg::RESP_OKAY : ast_pkg::RESP_SLVERR;
    end else if (i_axi_bready) begin
      o_axi_bvalid <= 1'b0;
    end
  end

  // Register writes
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      cfg_q <= '0;
      div_lo_q <= 8'h00;
      div_hi_q <= 8'h00;
    end else if (wr_ok && wstrb0_q) begin
      unique case (awaddr_q)
        ast_pkg::OFS_TX_CTRL: begin
          cfg_q.tx9 <= wdata_q[ast_pkg::B_TX9];
          cfg_q.transmit_enable <= wdata_q[ast_pkg::B_TRANSMIT_ENABLE];
          cfg_q.sync <= wdata_q[ast_pkg::B_SYNC];
          cfg_q.high_baud_select <= wdata_q[ast_pkg::B_HIGH_BAUD_SELECT];
          cfg_q.transmit_ninth_bit <= wdata_q[ast_pkg::B_TRANSMIT_NINTH_BIT];
        end
        ast_pkg::OFS_RX_STAT: begin
          cfg_q.serial_port_enable <= wdata_q[ast_pkg::B_SERIAL_PORT_ENABLE];
          cfg_q.rx9 <= wdata_q[ast_pkg::B_RX9];
          cfg_q.continuous_receive_enable <= wdata_q[ast_pkg::B_CONTINUOUS_RECEIVE_ENABLE];
          cfg_q.address_detect_enable <= wdata_q[ast_pkg::B_ADDRESS_DETECT_ENABLE];
        end
        ast_pkg::OFS_BAUD_CTRL: begin
          cfg_q.receive_polarity <= wdata_q[ast_pkg::B_RECEIVE_POLARITY];
          cfg_q.transmit_polarity <= wdata_q[ast_pkg::B_TRANSMIT_POLARITY];
          cfg_q.wide_divisor_select <= wdata_q[ast_pkg::B_WIDE_DIVISOR_SELECT];
        end
        ast_pkg::OFS_DIV_LO: div_lo_q <= wdata_q;
        ast_pkg::OFS_DIV_HI: div_hi_q <= wdata_q;
        ast_pkg::OFS_ENABLES: begin
          cfg_q.transmit_interrupt_enable <= wdata_q[ast_pkg::B_TRANSMIT_BUFFER_EMPTY_FLAG];
          cfg_q.receive_interrupt_enable <= wdata_q[ast_pkg::B_RECEIVE_COMPLETE_FLAG];
        end
        default: ;
      endcase
    end
  end

  // AXI4-Lite read path, one cycle after the address is taken
  assign o_axi_arready = !o_axi_rvalid;
  assign rd_go = i_axi_arvalid && o_axi_arready;
  assign rxbuf_rd = rd_go && (i_axi_araddr == ast_pkg::OFS_RX_BUF);

  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      o_axi_rvalid <= 1'b0;
      o_axi_rdata <= '0;
      o_axi_rresp <= ast_pkg::RESP_OKAY;
    end else if (rd_go) begin
      o_axi_rvalid <= 1'b1;
      o_axi_rresp <= is_mapped(i_axi_araddr) ? ast_pkg::RESP_OKAY : ast_pkg::RESP_SLVERR;
      o_axi_rdata <= '0;
      unique case (i_axi_araddr)
        ast_pkg::OFS_TX_CTRL: o_axi_rdata[7:0] <= {1'b0, cfg_q.tx9, cfg_q.transmit_enable, cfg_q.sync, 1'b0,
          cfg_q.high_baud_select, tx_st_q == ast_pkg::ST_IDLE, cfg_q.transmit_ninth_bit};
        ast_pkg::OFS_RX_STAT: o_axi_rdata[7:0] <= {cfg_q.serial_port_enable, cfg_q.rx9, 1'b0, cfg_q.continuous_receive_enable,
          cfg_q.address_detect_enable, ferr_q, oerr_q, rx9d_q};
        ast_pkg::OFS_BAUD_CTRL: o_axi_rdata[7:0] <= {2'h0, cfg_q.receive_polarity, cfg_q.transmit_polarity, cfg_q.wide_divisor_select, 3'h0};
        ast_pkg::OFS_DIV_LO: o_axi_rdata[7:0] <= div_lo_q;
        ast_pkg::OFS_DIV_HI: o_axi_rdata[7:0] <= div_hi_q;
        ast_pkg::OFS_TX_BUF: o_axi_rdata[7:0] <= txbuf_q;
        ast_pkg::OFS_RX_BUF: o_axi_rdata[7:0] <= rxbuf_q;
        ast_pkg::OFS_FLAGS: o_axi_rdata[7:0] <= {2'h0, receive_complete_flag_q, transmit_buffer_empty_flag_q, 4'h0};
        ast_pkg::OFS_ENABLES: o_axi_rdata[7:0] <= {2'h0, cfg_q.receive_interrupt_enable, cfg_q.transmit_interrupt_enable, 4'h0};
        default: ;
      endcase
    end else if (i_axi_rready) begin
      o_axi_rvalid <= 1'b0;
    end
  end

  // Shared baud generator; no parity logic anywhere
  assign active = cfg_q.serial_port_enable && !cfg_q.sync;
  assign divisor = cfg_q.wide_divisor_select ? {div_hi_q, div_lo_q} : {8'h00, div_lo_q};
  assign ovs_last = (cfg_q.high_baud_select || cfg_q.wide_divisor_select) ? ast_pkg::OVS16_LAST : ast_pkg::OVS64_LAST;
  assign tick = active && (baud_cnt_q == 16'h0000);

  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n || !active || baud_cnt_q == 16'h0000) begin
      baud_cnt_q <= (!i_rst_n) ? 16'h0000 : divisor;
    end else begin
      baud_cnt_q <= baud_cnt_q - 16'h0001;
    end
  end

  // Transmit buffer and empty flag
  assign tx_load = active && cfg_q.transmit_enable && txbuf_full_q &&
    (tx_st_q == ast_pkg::ST_IDLE ||
     (tx_st_q == ast_pkg::ST_STOP && tick && tx_ph_q == ovs_last));

  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      txbuf_q <= 8'h00;
      txbuf_full_q <= 1'b0;
    end else if (txbuf_wr && wstrb0_q) begin
      txbuf_q <= wdata_q;
      txbuf_full_q <= 1'b1;
    end else if (tx_load || !cfg_q.transmit_enable) begin
      txbuf_full_q <= 1'b0;
    end
  end

  // Flag follows buffer state one cycle late; interrupt enable bit never touches it
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      transmit_buffer_empty_flag_q <= 1'b0;
    end else begin
      transmit_buffer_empty_flag_q <= cfg_q.transmit_enable && !txbuf_full_q;
    end
  end

  // Transmitter
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n || !active || !cfg_q.transmit_enable) begin
      tx_st_q <= ast_pkg::ST_IDLE;
      tx_ph_q <= 6'h00;
      tx_bit_q <= 4'h0;
      tsr_q <= 9'h000;
    end else if (tx_load) begin
      tx_st_q <= ast_pkg::ST_START;
      tx_ph_q <= 6'h00;
      tx_bit_q <= 4'h0;
      tsr_q <= {cfg_q.transmit_ninth_bit, txbuf_q};
    end else if (tick && tx_st_q != ast_pkg::ST_IDLE) begin
      tx_ph_q <= (tx_ph_q == ovs_last) ? 6'h00 : tx_ph_q + 6'h01;
      if (tx_ph_q == ovs_last) begin
        unique case (tx_st_q)
          ast_pkg::ST_START: tx_st_q <= ast_pkg::ST_DATA;
          ast_pkg::ST_DATA: begin
            tsr_q <= {1'b0, tsr_q[8:1]};
            tx_bit_q <= tx_bit_q + 4'h1;
            if (tx_bit_q == (cfg_q.tx9 ? ast_pkg::BITS9_LAST : ast_pkg::BITS8_LAST)) begin
              tx_st_q <= ast_pkg::ST_STOP;
            end
          end
          ast_pkg::ST_STOP: tx_st_q <= ast_pkg::ST_IDLE;
          ast_pkg::ST_IDLE: ;
        endcase
      end
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      o_tx_line <= 1'b1;
    end else begin
      o_tx_line <= cfg_q.transmit_polarity ^ ((tx_st_q == ast_pkg::ST_START) ? 1'b0 :
        (tx_st_q == ast_pkg::ST_DATA) ? tsr_q[0] : 1'b1);
    end
  end

  // Receiver: start edge found at tick rate, bits sampled at mid-bit
  assign rx_s = i_rx_line ^ cfg_q.receive_polarity;
  assign rx_done = tick && rx_st_q == ast_pkg::ST_STOP && rx_ph_q == ovs_last;
  // Address detection drops frames whose ninth bit is zero
  assign rx_accept = rx_done && !(cfg_q.address_detect_enable && cfg_q.rx9 && !rsr_q[8]);

  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n || !active || !cfg_q.continuous_receive_enable) begin
      rx_st_q <= ast_pkg::ST_IDLE;
      rx_ph_q <= 6'h00;
      rx_bit_q <= 4'h0;
      rsr_q <= 9'h000;
    end else if (tick) begin
      rx_ph_q <= (rx_ph_q == ovs_last) ? 6'h00 : rx_ph_q + 6'h01;
      unique case (rx_st_q)
        ast_pkg::ST_IDLE: begin
          rx_ph_q <= 6'h00;
          rx_bit_q <= 4'h0;
          if (!rx_s) begin
            rx_st_q <= ast_pkg::ST_START;
          end
        end
        ast_pkg::ST_START: begin
          // Re-check at mid-bit so a glitch does not start a frame
          if (rx_ph_q == {1'b0, ovs_last[5:1]}) begin
            rx_ph_q <= 6'h00;
            rx_st_q <= rx_s ? ast_pkg::ST_IDLE : ast_pkg::ST_DATA;
          end
        end
        ast_pkg::ST_DATA: begin
          if (rx_ph_q == ovs_last) begin
            rx_bit_q <= rx_bit_q + 4'h1;
            if (cfg_q.rx9) begin
              rsr_q <= {rx_s, rsr_q[8:1]};
            end else begin
              rsr_q <= {1'b0, rx_s, rsr_q[7:1]};
            end
            if (rx_bit_q == (cfg_q.rx9 ? ast_pkg::BITS9_LAST : ast_pkg::BITS8_LAST)) begin
              rx_st_q <= ast_pkg::ST_STOP;
            end
          end
        end
        ast_pkg::ST_STOP: begin
          if (rx_ph_q == ovs_last) begin
            rx_st_q <= ast_pkg::ST_IDLE;
          end
        end
      endcase
    end
  end

  // Receive buffer, flag and errors; a new frame wins over a buffer read
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      rxbuf_q <= 8'h00;
      rx9d_q <= 1'b0;
      receive_complete_flag_q <= 1'b0;
      ferr_q <= 1'b0;
      oerr_q <= 1'b0;
    end else begin
      // A read in the same cycle takes the old byte, so the new frame may land
      if (rx_accept && (!receive_complete_flag_q || rxbuf_rd)) begin
        rxbuf_q <= rsr_q[7:0];
        rx9d_q <= rsr_q[8];
        ferr_q <= !rx_s;
        receive_complete_flag_q <= 1'b1;
      end else if (rxbuf_rd) begin
        receive_complete_flag_q <= 1'b0;
      end
      if (rx_accept && receive_complete_flag_q && !rxbuf_rd) begin
        oerr_q <= 1'b1;
      end
      if (!cfg_q.continuous_receive_enable) begin
        ferr_q <= 1'b0;
        oerr_q <= 1'b0;
      end
    end
  end

  // Requests only; global enables sit in the processor core
  assign o_tx_irq_req = transmit_buffer_empty_flag_q && cfg_q.transmit_interrupt_enable;
  assign o_rx_irq_req = receive_complete_flag_q && cfg_q.receive_interrupt_enable;

  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (!i_rst_n);

  property p_transmit_buffer_empty_flag_clears;
    txbuf_wr && wstrb0_q && tx_st_q != ast_pkg::ST_IDLE |-> ##2 !transmit_buffer_empty_flag_q;
  endproperty
  a_transmit_buffer_empty_flag_clears: assert property (p_transmit_buffer_empty_flag_clears) else $error("empty flag not cleared after write");

  property p_transmit_buffer_empty_flag_sets;
    tx_load && !txbuf_wr |-> ##2 transmit_buffer_empty_flag_q;
  endproperty
  a_transmit_buffer_empty_flag_sets: assert property (p_transmit_buffer_empty_flag_sets) else $error("empty flag not set after load");

  property p_idle_line;
    tx_st_q == ast_pkg::ST_IDLE && $stable(cfg_q.transmit_polarity) |=> o_tx_line == !$past(cfg_q.transmit_polarity);
  endproperty
  a_idle_line: assert property (p_idle_line) else $error("idle line level wrong");

  property p_start_bit;
    tx_load ##1 tx_st_q == ast_pkg::ST_START && $stable(cfg_q.transmit_polarity) |=> o_tx_line == $past(cfg_q.transmit_polarity);
  endproperty
  a_start_bit: assert property (p_start_bit) else $error("start bit level wrong");

  property p_lsb_first;
    tick && tx_st_q == ast_pkg::ST_DATA && tx_ph_q == ovs_last && active && cfg_q.transmit_enable && !tx_load
      |=> tsr_q[7:0] == $past(tsr_q[8:1]);
  endproperty
  a_lsb_first: assert property (p_lsb_first) else $error("shift order wrong");

  property p_rx_flag;
    rx_accept && !receive_complete_flag_q |=> receive_complete_flag_q && rxbuf_q == $past(rsr_q[7:0]);
  endproperty
  a_rx_flag: assert property (p_rx_flag) else $error("frame not delivered");

  property p_addr_drop;
    rx_done && cfg_q.address_detect_enable && cfg_q.rx9 && !rsr_q[8] && !receive_complete_flag_q |=> !receive_complete_flag_q;
  endproperty
  a_addr_drop: assert property (p_addr_drop) else $error("data frame accepted in address mode");

  property p_ferr;
    rx_accept && !receive_complete_flag_q && !rx_s && cfg_q.continuous_receive_enable |=> ferr_q;
  endproperty
  a_ferr: assert property (p_ferr) else $error("framing error missed");

  property p_err_clear;
    !cfg_q.continuous_receive_enable |=> !ferr_q && !oerr_q;
  endproperty
  a_err_clear: assert property (p_err_clear) else $error("errors kept with receive disabled");
endmodule
`default_nettype wire

/* dv/ast_peer.sv */
// Purpose: Remote serial peer that frames bytes onto the line and checks them off it
// Assumes: Bit period is given in system clocks and polarity per call
// Notes: Line is always driven; idle level follows the polarity last set
`default_nettype none
module ast_peer (
  input wire logic i_clk,
  input wire logic i_line,
  output logic o_line
);
  timeunit 1ns;
  timeprecision 1ps;
  initial o_line = 1'b1;
  task automatic set_idle(input logic pol);
    @(posedge i_clk);
    o_line <= !pol;
  endtask
  // Ninth bit comes from the caller, so any parity is the caller's own work
  task automatic send(input int bclk, input logic pol, input int nb, input logic [8:0] d, input logic stopv);
    @(posedge i_clk);
    o_line <= pol;
    repeat (bclk) @(posedge i_clk);
    for (int i = 0; i < nb; i++) begin
      o_line <= d[i] ^ pol;
      repeat (bclk) @(posedge i_clk);
    end
    o_line <= stopv ^ pol; // A low stop only when a test asks for it
    repeat (bclk) @(posedge i_clk);
    o_line <= !pol;
  endtask
  // Samples mid-bit; gives up after a bounded wait so a silent line cannot hang the run
  task automatic recv(input int bclk, input logic pol, input int nb, output logic [8:0] d, output logic ok,
                      output int waited);
    waited = 0;
    d = '0;
    ok = 1'b0;
    while (i_line !== !pol && waited < 4000) begin
      @(posedge i_clk);
      waited++;
    end
    while (i_line !== pol && waited < 4000) begin
      @(posedge i_clk);
      waited++;
    end
    if (waited < 4000) begin
      repeat (bclk / 2) @(posedge i_clk);
      for (int i = 0; i < nb; i++) begin
        repeat (bclk) @(posedge i_clk);
        d[i] = i_line ^ pol;
      end
      repeat (bclk) @(posedge i_clk);
      ok = i_line ^ pol;
    end
  endtask
endmodule
`default_nettype wire

/* dv/tb_async_serial_transceiver.sv */
// Purpose: Self-checking bench for the async serial transceiver
// Assumes: Divisor low byte 1, so a bit is 32 clocks at x16 and 128 clocks at x64
// Notes: Interrupt outputs are levels for an external controller, which holds the global enables
`default_nettype none
module tb_async_serial_transceiver;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {logic pol; logic [1:0] mode; logic nine; logic [8:0] data;} ast_row_s;
  localparam ast_row_s ROWS [4] = '{'{1'b0, 2'h0, 1'b0, 9'h0a5}, '{1'b1, 2'h1, 1'b1, 9'h13c},
                                    '{1'b0, 2'h2, 1'b1, 9'h081}, '{1'b1, 2'h2, 1'b0, 9'h07e}};
  logic sys_clk = 1'b0;
  logic rst_n, awvalid, wvalid, bready, arvalid, rready;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata;
  logic awready, wready, bvalid, arready, rvalid, rx_line, tx_line, tx_irq, rx_irq;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic [8:0] got_d;
  logic got_ok;
  int waited, fails, checked, bclk, nb;
  ast_row_s r;
  always #5 sys_clk = ~sys_clk;
  ast_top dut_u (.i_sys_clk(sys_clk), .i_rst_n(rst_n), .i_axi_awvalid(awvalid), .o_axi_awready(awready),
    .i_axi_awaddr(awaddr), .i_axi_wvalid(wvalid), .o_axi_wready(wready), .i_axi_wdata(wdata),
    .i_axi_wstrb(4'hf), .o_axi_bvalid(bvalid), .i_axi_bready(bready), .o_axi_bresp(bresp),
    .i_axi_arvalid(arvalid), .o_axi_arready(arready), .i_axi_araddr(araddr), .o_axi_rvalid(rvalid),
    .i_axi_rready(rready), .o_axi_rdata(rdata), .o_axi_rresp(rresp), .i_rx_line(rx_line),
    .o_tx_line(tx_line), .o_tx_irq_req(tx_irq), .o_rx_irq_req(rx_irq));
  ast_peer peer_u (.i_clk(sys_clk), .i_line(tx_line), .o_line(rx_line));
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      fails++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er = ast_pkg::RESP_OKAY);
    logic aw_ok, w_ok;
    int n;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    n = 0;
    @(posedge sys_clk);
    awvalid <= 1'b1;
    awaddr <= a;
    wvalid <= 1'b1;
    wdata <= {24'h0, d};
    bready <= 1'b1;
    while (!(aw_ok && w_ok) && n < 50) begin
      @(posedge sys_clk);
      n++;
      if (!aw_ok && awready === 1'b1) begin
        aw_ok = 1'b1;
        awvalid <= 1'b0;
      end
      if (!w_ok && wready === 1'b1) begin
        w_ok = 1'b1;
        wvalid <= 1'b0;
      end
    end
    while (bvalid !== 1'b1 && n < 100) begin
      @(posedge sys_clk);
      n++;
    end
    cmp({31'h0, bvalid}, 32'h1);
    cmp({30'h0, bresp}, {30'h0, er});
    bready <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er = ast_pkg::RESP_OKAY);
    int n;
    n = 0;
    @(posedge sys_clk);
    arvalid <= 1'b1;
    araddr <= a;
    rready <= 1'b1;
    do begin
      @(posedge sys_clk);
      n++;
    end while (arready !== 1'b1 && n < 50);
    arvalid <= 1'b0;
    while (rvalid !== 1'b1 && n < 100) begin
      @(posedge sys_clk);
      n++;
    end
    cmp({31'h0, rvalid}, 32'h1);
    cmp(rdata, exp);
    cmp({30'h0, rresp}, {30'h0, er});
    rready <= 1'b0;
  endtask
  task automatic wait_rx(input logic exp, input int lim);
    int n;
    n = 0;
    while (rx_irq !== 1'b1 && n < lim) begin
      @(posedge sys_clk);
      n++;
    end
    cmp({31'h0, rx_irq}, {31'h0, exp});
  endtask
  task automatic close_out();
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  initial begin
    repeat (60000) @(posedge sys_clk);
    fails++;
    close_out();
  end
  initial begin
    {rst_n, awvalid, wvalid, bready, arvalid, rready, awaddr, araddr, wdata} = '0;
    repeat (12) @(posedge sys_clk);
    rst_n <= 1'b1;
    rd(ast_pkg::OFS_TX_CTRL, 32'h02);
    rd(ast_pkg::OFS_FLAGS, 32'h00);
    rd(8'h24, 32'h00, ast_pkg::RESP_SLVERR);
    wr(8'h06, 8'hff, ast_pkg::RESP_SLVERR);
    wr(ast_pkg::OFS_ENABLES, 8'h30);
    wr(ast_pkg::OFS_DIV_LO, 8'h01);
    for (int i = 0; i < 4; i++) begin
      r = ROWS[i];
      bclk = (r.mode == 2'h0) ? 128 : 32;
      nb = r.nine ? 9 : 8;
      wr(ast_pkg::OFS_RX_STAT, 8'h80); // Receiver off so a polarity swap is not seen as a start
      wr(ast_pkg::OFS_DIV_HI, {7'h0, r.mode != 2'h2});
      wr(ast_pkg::OFS_BAUD_CTRL, {2'h0, r.pol, r.pol, r.mode == 2'h2, 3'h0});
      peer_u.set_idle(r.pol);
      wr(ast_pkg::OFS_RX_STAT, {1'b1, r.nine, 6'h10});
      wr(ast_pkg::OFS_TX_CTRL, {1'b0, r.nine, 3'h4, r.mode == 2'h1, 1'b0, r.data[8]});
      rd(ast_pkg::OFS_FLAGS, 32'h10);
      cmp({31'h0, tx_irq}, 32'h1);
      wr(ast_pkg::OFS_TX_BUF, r.data[7:0]);
      fork
        peer_u.recv(bclk, r.pol, nb, got_d, got_ok, waited);
        peer_u.send(bclk, r.pol, nb, ~r.data, 1'b1);
      join
      cmp({31'h0, got_ok}, 32'h1);
      cmp({23'h0, got_d}, {23'h0, r.nine & r.data[8], r.data[7:0]});
      wait_rx(1'b1, 2 * bclk);
      if (r.nine) begin
        rd(ast_pkg::OFS_RX_STAT, {24'h0, 7'h68, ~r.data[8]});
      end
      rd(ast_pkg::OFS_RX_BUF, {24'h0, ~r.data[7:0]});
      rd(ast_pkg::OFS_FLAGS, 32'h10);
    end
    wr(ast_pkg::OFS_RX_STAT, 8'h80);
    wr(ast_pkg::OFS_BAUD_CTRL, 8'h08);
    peer_u.set_idle(1'b0);
    wr(ast_pkg::OFS_RX_STAT, 8'h90);
    wr(ast_pkg::OFS_ENABLES, 8'h20);
    wr(ast_pkg::OFS_FLAGS, 8'h00);
    rd(ast_pkg::OFS_FLAGS, 32'h10);
    cmp({31'h0, tx_irq}, 32'h0);
    wr(ast_pkg::OFS_TX_CTRL, 8'h20);
    // Peer listens before the first frame starts, or it would lock onto a data edge
    fork
      peer_u.recv(32, 1'b0, 8, got_d, got_ok, waited);
      begin
        wr(ast_pkg::OFS_TX_BUF, 8'h11);
        wr(ast_pkg::OFS_TX_BUF, 8'h22);
        rd(ast_pkg::OFS_FLAGS, 32'h00);
        rd(ast_pkg::OFS_TX_CTRL, 32'h20);
      end
    join
    cmp({23'h0, got_d}, 32'h11);
    peer_u.recv(32, 1'b0, 8, got_d, got_ok, waited);
    cmp({23'h0, got_d}, 32'h22);
    cmp({31'h0, waited <= 20}, 32'h1);
    repeat (32) @(posedge sys_clk);
    rd(ast_pkg::OFS_TX_CTRL, 32'h22);
    wr(ast_pkg::OFS_TX_CTRL, 8'h30);
    wr(ast_pkg::OFS_TX_BUF, 8'h55);
    peer_u.recv(32, 1'b0, 8, got_d, got_ok, waited);
    cmp({31'h0, got_ok}, 32'h0);
    wr(ast_pkg::OFS_TX_CTRL, 8'h00);
    peer_u.send(32, 1'b0, 8, 9'h0c3, 1'b0);
    wait_rx(1'b1, 64);
    rd(ast_pkg::OFS_RX_STAT, 32'h94);
    rd(ast_pkg::OFS_RX_BUF, 32'hc3);
    wr(ast_pkg::OFS_RX_STAT, 8'h80);
    rd(ast_pkg::OFS_RX_STAT, 32'h80);
    wr(ast_pkg::OFS_RX_STAT, 8'hd8);
    peer_u.send(32, 1'b0, 9, 9'h033, 1'b1);
    wait_rx(1'b0, 64);
    peer_u.send(32, 1'b0, 9, 9'h1a7, 1'b1);
    wait_rx(1'b1, 64);
    rd(ast_pkg::OFS_RX_BUF, 32'ha7);
    wr(ast_pkg::OFS_RX_STAT, 8'hd0);
    peer_u.send(32, 1'b0, 9, 9'h044, 1'b1);
    wait_rx(1'b1, 64);
    rd(ast_pkg::OFS_RX_BUF, 32'h44);
    close_out();
  end
endmodule
`default_nettype wire
